// file: rtl/can_timing_pkg.sv
/*
  Constants and types of the CAN bit timing and driver block.
  Assumes one clock domain, an 8-bit register port and a 3-bit address.
*/
package can_timing_pkg;

  // ---------------------------------------------------------------------------
  // register port and offsets
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_PRESCALE_JUMP = 3'h0;
  localparam logic [2:0] ADDR_SEGMENTS = 3'h1;
  localparam logic [2:0] ADDR_TX_DRIVER = 3'h2;
  localparam logic [2:0] ADDR_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_FRAME_BITS = 3'h5;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 5;
  localparam int JUMP_LSB = 6;
  localparam int JUMP_W = 2;
  localparam int SEG1_LSB = 0;
  localparam int SEG1_W = 4;
  localparam int SEG2_LSB = 4;
  localparam int SEG2_W = 3;
  localparam int SAMPLING_MODE_BIT = 7;
  localparam int OUT_MODE_LSB = 0;
  localparam int OUT0_POL_BIT = 2;
  localparam int OUT0_PULLDOWN_BIT = 3;
  localparam int OUT0_PULLUP_BIT = 4;
  localparam int OUT1_POL_BIT = 5;
  localparam int OUT1_PULLDOWN_BIT = 6;
  localparam int OUT1_PULLUP_BIT = 7;
  localparam int CTRL_TX_ENABLE_BIT = 0;
  localparam int CTRL_BYTES_LSB = 4;
  localparam int CTRL_BYTES_W = 4;
  localparam int STAT_TX_BUSY_BIT = 0;
  localparam int STAT_BUS_IDLE_BIT = 1;
  localparam int STAT_RX_LEVEL_BIT = 2;

  // ---------------------------------------------------------------------------
  // reset values: drivers off
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PRESCALE_JUMP_RST = 8'h00;
  localparam logic [7:0] SEGMENTS_RST = 8'h00;
  localparam logic [7:0] TX_DRIVER_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // output modes and frame figures
  // ---------------------------------------------------------------------------
  localparam logic [1:0] OUT_MODE_BIPHASE = 2'h0;
  localparam logic [1:0] OUT_MODE_TEST = 2'h1;
  localparam logic [1:0] OUT_MODE_NORMAL1 = 2'h2;
  localparam logic [1:0] OUT_MODE_CLOCK = 2'h3;
  localparam int CLOCKS_PER_PRESCALE_STEP = 2;
  localparam int REMOTE_FRAME_BITS = 44;
  localparam int INTERFRAME_BITS = 3;
  localparam int BITS_PER_DATA_BYTE = 8;
  localparam int MAX_DATA_BYTES = 8;

  // bit segment
  typedef enum logic [1:0] {SEG_SYNC, SEG_ONE, SEG_TWO} seg_t;

endpackage

// file: rtl/level_sync.sv
/*
  Two flip-flop synchroniser for a level from outside the clock domain.
  Assumes a slow input; only the second stage is read.
*/
module level_sync (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // level in and synchronised level out
  input wire logic level_i,
  output logic level_o
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // resets recessive, the bus idle level
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = level_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '{meta: 1'b1, stable: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.stable;

endmodule

// file: rtl/bit_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes the filler honours in_ready_o; flags come from flip-flops.
*/
module bit_buffer #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // filling side
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // draining side
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic full;
    logic empty;
  } buf_state_t;

  buf_state_t s_r;
  buf_state_t s_nxt;
  logic push;
  logic pop;

  // push and pop may coincide
  always_comb begin
    s_nxt = s_r;
    push = in_valid_i & ~s_r.full;
    pop = out_ready_i & ~s_r.empty;
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = in_data_i;
      s_nxt.wr_ptr = ~s_r.wr_ptr;
    end
    if (pop) begin
      s_nxt.rd_ptr = ~s_r.rd_ptr;
    end
    if (push && !pop) begin
      s_nxt.empty = 1'b0;
      s_nxt.full = (~s_r.wr_ptr == s_r.rd_ptr);
    end else if (pop && !push) begin
      s_nxt.full = 1'b0;
      s_nxt.empty = (~s_r.rd_ptr == s_r.wr_ptr);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '{mem: '0, wr_ptr: 1'b0, rd_ptr: 1'b0, full: 1'b0, empty: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready_o = ~s_r.full;
  assign out_valid_o = ~s_r.empty;
  assign out_data_o = s_r.mem[s_r.rd_ptr];

endmodule

// file: rtl/can_bit_timing_output_ctrl.sv
/*
  CAN bit timing engine and transmit driver control:
  timing registers, quantum counting, sampling,
  resynchronisation and the two transmit pins.
  Assumes one clock, a plain register port,
  a bit source that honours ready
  and a transceiver that resolves pins from enables.
*/
// Chosen here: the address-and-strobe port and the register offsets.
module can_bit_timing_output_ctrl
  import can_timing_pkg::*;
// Summary of operation
// - time quantum is clock divided by two times one more than the five-bit prescaler field.
// - segment lengths before and after sample point come from segment register.
// - sampling-mode bit zero samples each received bit once.
// - each resynchronisation step is limited to the programmed jump width.
// - each output enables pull-up, pull-down or both per its enable bits, in every output mode but mode 0.
// - output mode high-set low-clear drives the bit stream on both outputs.
// - polarity bit zero passes the stream, one inverts it, per output.
// - one transmit path; a new bit enters while the two-entry buffer is not full.
// - remote frame takes 44 bit times plus a 3-bit interframe space.
// - each data byte up to eight adds eight bit times to the minimum frame; larger byte counts add no more.
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // bit stream to send, 0 is dominant
  input wire logic tx_bit_i,
  input wire logic tx_bit_valid_i,
  output logic tx_bit_ready_o,
  // bit stream received
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  // bus pins
  input wire logic can_rx_i,
  output logic transmit_output_a_o,
  output logic transmit_output_a_oe_o,
  output logic transmit_output_b_o,
  output logic transmit_output_b_oe_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prescale_jump;
    logic [7:0] segments;
    logic [7:0] tx_driver;
    logic [7:0] control;
    logic [7:0] rdata;
    seg_t seg;
    logic [5:0] presc_cnt;
    logic [4:0] seg_cnt;
    logic [4:0] seg_lim;
    logic resync_done;
    logic rx_prev;
    logic [1:0] rx_hist;
    logic tx_bit;
    logic tx_busy;
    logic [1:0] idle_cnt;
    logic bus_idle;
    logic rx_bit;
    logic rx_valid;
    logic a_out;
    logic a_oe;
    logic b_out;
    logic b_oe;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic rx_s;
  logic buf_data;
  logic buf_valid;
  logic buf_pop;

  // majority of three for triple sampling
  function automatic logic majority3(input logic [2:0] v);
    majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // one pin: level and enable from stream, polarity, drivers
  function automatic logic [1:0] pin_drive(input logic stream, input logic pol,
                                           input logic up_en, input logic dn_en);
    logic lvl;
    lvl = stream ^ pol;
    pin_drive = {lvl, (lvl ? up_en : dn_en)};
  endfunction

  // ---------------------------------------------------------------------------
  // receive pin synchroniser and transmit buffer
  // ---------------------------------------------------------------------------
  level_sync u_rx_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(can_rx_i),
    .level_o(rx_s)
  );

  bit_buffer #(.W(1)) u_tx_buf (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(tx_bit_i),
    .in_valid_i(tx_bit_valid_i),
    .in_ready_o(tx_bit_ready_o),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop)
  );

  // ---------------------------------------------------------------------------
  // decoded fields
  // ---------------------------------------------------------------------------
  logic [5:0] presc_top;
  logic [4:0] seg1_len;
  logic [4:0] seg2_len;
  logic [4:0] jump_len;
  logic sampling_mode_bit;
  logic [1:0] out_mode;
  logic tx_enable;
  logic [3:0] data_bytes;
  logic [7:0] frame_bits;

  assign presc_top = {s_r.prescale_jump[PRESCALE_LSB +: PRESCALE_W], 1'b1};
  assign seg1_len = {1'b0, s_r.segments[SEG1_LSB +: SEG1_W]} + 5'h01;
  assign seg2_len = {2'h0, s_r.segments[SEG2_LSB +: SEG2_W]} + 5'h01;
  assign jump_len = {3'h0, s_r.prescale_jump[JUMP_LSB +: JUMP_W]} + 5'h01;
  assign sampling_mode_bit = s_r.segments[SAMPLING_MODE_BIT];
  assign out_mode = s_r.tx_driver[OUT_MODE_LSB +: 2];
  assign tx_enable = s_r.control[CTRL_TX_ENABLE_BIT];

  always_comb begin
    data_bytes = s_r.control[CTRL_BYTES_LSB +: CTRL_BYTES_W];
    if (data_bytes > 4'(MAX_DATA_BYTES)) begin
      data_bytes = 4'(MAX_DATA_BYTES);
    end
    frame_bits = 8'(REMOTE_FRAME_BITS + INTERFRAME_BITS)
               + 8'(data_bytes * BITS_PER_DATA_BYTE);
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic tq_tick;
  logic seg_end;
  logic fall;
  logic start_bit;
  logic sample_now;
  logic sample_val;
  logic [4:0] phase_err;
  logic [4:0] remain;
  logic stream;
  logic [1:0] drv_a;
  logic [1:0] drv_b;

  always_comb begin
    s_nxt = s_r;
    tq_tick = (s_r.presc_cnt == presc_top);
    seg_end = tq_tick & (s_r.seg_cnt == s_r.seg_lim - 5'h01);
    fall = s_r.rx_prev & ~rx_s;
    start_bit = 1'b0;
    sample_now = 1'b0;
    phase_err = s_r.seg_cnt + 5'h01;
    remain = s_r.seg_lim - s_r.seg_cnt;
    s_nxt.rx_valid = 1'b0;
    s_nxt.rx_prev = rx_s;

    // register writes; status and frame length are read-only
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_PRESCALE_JUMP) begin
        s_nxt.prescale_jump = reg_wdata_i;
      end else if (reg_addr_i == ADDR_SEGMENTS) begin
        s_nxt.segments = reg_wdata_i;
      end else if (reg_addr_i == ADDR_TX_DRIVER) begin
        s_nxt.tx_driver = reg_wdata_i;
      end else if (reg_addr_i == ADDR_CONTROL) begin
        s_nxt.control = reg_wdata_i;
      end
    end

    // read data stand one cycle; unmapped reads zero
    s_nxt.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_PRESCALE_JUMP) begin
        s_nxt.rdata = s_r.prescale_jump;
      end else if (reg_addr_i == ADDR_SEGMENTS) begin
        s_nxt.rdata = s_r.segments;
      end else if (reg_addr_i == ADDR_TX_DRIVER) begin
        s_nxt.rdata = s_r.tx_driver;
      end else if (reg_addr_i == ADDR_CONTROL) begin
        s_nxt.rdata = s_r.control;
      end else if (reg_addr_i == ADDR_STATUS) begin
        s_nxt.rdata[STAT_TX_BUSY_BIT] = s_r.tx_busy;
        s_nxt.rdata[STAT_BUS_IDLE_BIT] = s_r.bus_idle;
        s_nxt.rdata[STAT_RX_LEVEL_BIT] = s_r.rx_bit;
      end else if (reg_addr_i == ADDR_FRAME_BITS) begin
        s_nxt.rdata = frame_bits;
      end
    end

    // prescaler counts two clocks per step
    if (tq_tick) begin
      s_nxt.presc_cnt = 6'h00;
      s_nxt.rx_hist = {s_r.rx_hist[0], rx_s};
    end else begin
      s_nxt.presc_cnt = s_r.presc_cnt + 6'h01;
    end

    if (tq_tick) begin
      if (seg_end) begin
        s_nxt.seg_cnt = 5'h00;
        case (s_r.seg)
          SEG_SYNC: begin
            s_nxt.seg = SEG_ONE;
            s_nxt.seg_lim = seg1_len;
          end
          SEG_ONE: begin
            s_nxt.seg = SEG_TWO;
            s_nxt.seg_lim = seg2_len;
            sample_now = 1'b1;
          end
          default: begin
            s_nxt.seg = SEG_SYNC;
            s_nxt.seg_lim = 5'h01;
            start_bit = 1'b1;
          end
        endcase
      end else begin
        s_nxt.seg_cnt = s_r.seg_cnt + 5'h01;
      end
    end

    // edges: hard sync while idle, else one bounded resync per bit
    // resync edges on a segment-end tick are ignored; hard sync still applies
    if (fall && s_r.bus_idle && !s_r.tx_busy) begin
      s_nxt.seg = SEG_SYNC;
      s_nxt.seg_cnt = 5'h00;
      s_nxt.seg_lim = 5'h01;
      s_nxt.presc_cnt = 6'h00;
      start_bit = 1'b1;
    end else if (fall && !s_r.resync_done && !seg_end) begin
      if (s_r.seg == SEG_ONE) begin
        // lengthen segment one, capped by jump
        s_nxt.seg_lim = s_r.seg_lim + ((phase_err < jump_len) ? phase_err : jump_len);
        s_nxt.resync_done = 1'b1;
      end else if (s_r.seg == SEG_TWO) begin
        // shorten segment two, capped by jump
        if (remain <= jump_len) begin
          s_nxt.seg = SEG_SYNC;
          s_nxt.seg_cnt = 5'h00;
          s_nxt.seg_lim = 5'h01;
          s_nxt.presc_cnt = 6'h00;
          start_bit = 1'b1;
        end else begin
          s_nxt.seg_lim = s_r.seg_lim - jump_len;
          s_nxt.resync_done = 1'b1;
        end
      end
    end

    // sample point at the end of segment one
    // one sample unless sampling-mode bit set
    sample_val = sampling_mode_bit ? majority3({s_r.rx_hist, rx_s}) : rx_s;
    if (sample_now) begin
      s_nxt.rx_bit = sample_val;
      s_nxt.rx_valid = 1'b1;
      if (!sample_val) begin
        s_nxt.idle_cnt = 2'h0;
      end else if (s_r.idle_cnt != 2'(INTERFRAME_BITS)) begin
        s_nxt.idle_cnt = s_r.idle_cnt + 2'h1;
      end
      s_nxt.bus_idle = sample_val && (s_r.idle_cnt >= 2'(INTERFRAME_BITS - 1));
    end

    // pop only at a bit start
    buf_pop = start_bit & tx_enable & buf_valid;
    if (start_bit) begin
      s_nxt.resync_done = 1'b0;
      s_nxt.tx_bit = buf_pop ? buf_data : 1'b1;
      s_nxt.tx_busy = buf_pop;
    end

    case (out_mode)
      OUT_MODE_NORMAL1: stream = s_nxt.tx_bit;
      OUT_MODE_CLOCK: stream = (s_nxt.seg != SEG_TWO);
      OUT_MODE_TEST: stream = rx_s;
      default: stream = 1'b1;
    endcase

    drv_a = pin_drive(stream, s_r.tx_driver[OUT0_POL_BIT],
                      s_r.tx_driver[OUT0_PULLUP_BIT], s_r.tx_driver[OUT0_PULLDOWN_BIT]);
    drv_b = pin_drive(stream, s_r.tx_driver[OUT1_POL_BIT],
                      s_r.tx_driver[OUT1_PULLUP_BIT], s_r.tx_driver[OUT1_PULLDOWN_BIT]);
    // mode 0 leaves pins off; else enable follows the pull-up or pull-down bit
    s_nxt.a_out = drv_a[1];
    s_nxt.a_oe = drv_a[0] & (out_mode != OUT_MODE_BIPHASE);
    s_nxt.b_out = drv_b[1];
    s_nxt.b_oe = drv_b[0] & (out_mode != OUT_MODE_BIPHASE);
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '{prescale_jump: PRESCALE_JUMP_RST, segments: SEGMENTS_RST,
               tx_driver: TX_DRIVER_RST, control: CONTROL_RST, rdata: 8'h00,
               seg: SEG_SYNC, presc_cnt: 6'h00, seg_cnt: 5'h00, seg_lim: 5'h01,
               resync_done: 1'b0, rx_prev: 1'b1, rx_hist: 2'h3, tx_bit: 1'b1,
               tx_busy: 1'b0, idle_cnt: 2'h0, bus_idle: 1'b0, rx_bit: 1'b1,
               rx_valid: 1'b0, a_out: 1'b1, a_oe: 1'b0, b_out: 1'b1, b_oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs from flip-flops
  // ---------------------------------------------------------------------------
  assign reg_rdata_o = s_r.rdata;
  assign rx_bit_o = s_r.rx_bit;
  assign rx_bit_valid_o = s_r.rx_valid;
  assign transmit_output_a_o = s_r.a_out;
  assign transmit_output_a_oe_o = s_r.a_oe;
  assign transmit_output_b_o = s_r.b_out;
  assign transmit_output_b_oe_o = s_r.b_oe;

endmodule

// file: tb/can_timing_sva.sv
/*
  Assertions for the CAN bit timing block, bound to its ports.
  Assumes one clock; config is shadowed from register writes.
*/
module can_timing_sva
  import can_timing_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // bit streams
  input wire logic tx_bit_valid_i,
  input wire logic tx_bit_ready_o,
  input wire logic rx_bit_o,
  input wire logic rx_bit_valid_o,
  // pins
  input wire logic can_rx_i,
  input wire logic transmit_output_a_o,
  input wire logic transmit_output_a_oe_o,
  input wire logic transmit_output_b_o,
  input wire logic transmit_output_b_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // -------------------------------------------------------------------------
  // helper state
  // -------------------------------------------------------------------------
  logic [7:0] pj_r, sg_r, dv_r;
  logic [1:0] wa_r, ra_r;
  logic [3:0] st_r;
  logic [11:0] gap_r, exp_gap;
  logic rxp_r, rx_chg;

  assign rx_chg = can_rx_i != rxp_r;
  // nominal bit in clocks
  assign exp_gap = 12'(CLOCKS_PER_PRESCALE_STEP * (pj_r[4:0] + 1) * (3 + sg_r[3:0] + sg_r[6:4]));

  // shadows and quiet counters
  always_ff @(posedge ref_clk_i) begin
    rxp_r <= can_rx_i;
    if (sys_rst_i) begin
      pj_r <= 8'h00;
      sg_r <= 8'h00;
      dv_r <= 8'h00;
      wa_r <= 2'h0;
      ra_r <= 2'h0;
      st_r <= 4'h0;
      gap_r <= 12'h000;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_PRESCALE_JUMP) pj_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == ADDR_SEGMENTS) sg_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == ADDR_TX_DRIVER) dv_r <= reg_wdata_i;
      wa_r <= reg_wr_i ? 2'h0 : (rx_bit_valid_o && wa_r != 2'h3) ? wa_r + 2'h1 : wa_r;
      ra_r <= rx_chg ? 2'h0 : (rx_bit_valid_o && ra_r != 2'h3) ? ra_r + 2'h1 : ra_r;
      st_r <= rx_chg ? 4'h0 : (st_r == 4'hF) ? st_r : st_r + 4'h1;
      gap_r <= rx_bit_valid_o ? 12'h001 : gap_r + 12'h001;
    end
  end

  // -------------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_read_data_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data without read");
  a_reset_outputs: assert property ($fell(sys_rst_i) |-> tx_bit_ready_o && !rx_bit_valid_o
    && !transmit_output_a_oe_o && !transmit_output_b_oe_o)
    else $error("outputs not at reset values");
  a_sample_pulse: assert property (rx_bit_valid_o |=> !rx_bit_valid_o [*3])
    else $error("sample pulses too close");
  a_bit_length: assert property (rx_bit_valid_o && wa_r == 2'h3 && ra_r == 2'h3 |->
    gap_r == exp_gap)
    else $error("wrong bit time");
  a_single_sample: assert property (!sg_r[SAMPLING_MODE_BIT] && rx_bit_valid_o &&
    st_r > 4'h7 |-> rx_bit_o == can_rx_i)
    else $error("wrong sampled bit");
  a_out_a_enable: assert property (wa_r > 2'h1 && dv_r[1:0] == OUT_MODE_NORMAL1 |->
    transmit_output_a_oe_o == (transmit_output_a_o ? dv_r[OUT0_PULLUP_BIT] : dv_r[OUT0_PULLDOWN_BIT]))
    else $error("pin A enable wrong");
  a_out_b_enable: assert property (wa_r > 2'h1 && dv_r[1:0] == OUT_MODE_NORMAL1 |->
    transmit_output_b_oe_o == (transmit_output_b_o ? dv_r[OUT1_PULLUP_BIT] : dv_r[OUT1_PULLDOWN_BIT]))
    else $error("pin B enable wrong");
  a_out_polarity: assert property (wa_r > 2'h1 && dv_r[1:0] == OUT_MODE_NORMAL1 |->
    (transmit_output_a_o ^ dv_r[OUT0_POL_BIT]) == (transmit_output_b_o ^ dv_r[OUT1_POL_BIT]))
    else $error("pins differ in stream");
  a_biphase_off: assert property (wa_r > 2'h1 && dv_r[1:0] == OUT_MODE_BIPHASE |->
    !transmit_output_a_oe_o && !transmit_output_b_oe_o)
    else $error("pins driven in mode 0");
  a_ready_refuse: assert property ($fell(tx_bit_ready_o) |-> $past(tx_bit_valid_i))
    else $error("ready fell without a bit");
endmodule

bind can_bit_timing_output_ctrl can_timing_sva i_can_timing_sva (.ref_clk_i, .sys_rst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tx_bit_valid_i,
  .tx_bit_ready_o, .rx_bit_o, .rx_bit_valid_o, .can_rx_i, .transmit_output_a_o,
  .transmit_output_a_oe_o, .transmit_output_b_o, .transmit_output_b_oe_o);

// file: tb/can_bus_model.sv
/*
  Bus, termination and transceiver seen from the block's pins.
  Assumes pin A pulls low and pin B pushes high when enabled.
*/
module can_bus_model (
  // clock
  input wire logic ref_clk_i,
  // pins of the block
  input wire logic transmit_output_a_o,
  input wire logic transmit_output_a_oe_o,
  input wire logic transmit_output_b_o,
  input wire logic transmit_output_b_oe_o,
  // other nodes and transceiver speed
  input wire logic other_dom_i,
  input wire logic slow_i,
  // received level, 0 is dominant
  output logic can_rx_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic dom;
  logic [2:0] dly_r = 3'h7;

  // enabled transistor or other node is dominant
  assign dom = (transmit_output_a_oe_o && !transmit_output_a_o) ||
    (transmit_output_b_oe_o && transmit_output_b_o) || other_dom_i;
  // transceiver delay; slow path eats sample margin
  always_ff @(posedge ref_clk_i) dly_r <= {dly_r[1:0], !dom};
  assign can_rx_o = slow_i ? dly_r[2] : dly_r[0];
endmodule

// file: tb/can_bit_timing_output_ctrl_tb.sv
/*
  Self-checking bench for the CAN bit timing block.
  Assumes the bus model loops the pins back to the receive pin.
*/
module can_bit_timing_output_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import can_timing_pkg::*;
  logic ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, tx_bit_i, tx_bit_valid_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, d, v;
  logic tx_bit_ready_o, rx_bit_o, rx_bit_valid_o, can_rx_i, other_dom, slow;
  logic transmit_output_a_o, transmit_output_a_oe_o, transmit_output_b_o, transmit_output_b_oe_o;
  logic feed, chk, go;
  int mismatches, cmp_count;
  logic q[$];

  can_bit_timing_output_ctrl i_can_bit_timing_output_ctrl (.ref_clk_i, .sys_rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tx_bit_i, .tx_bit_valid_i,
    .tx_bit_ready_o, .rx_bit_o, .rx_bit_valid_o, .can_rx_i, .transmit_output_a_o,
    .transmit_output_a_oe_o, .transmit_output_b_o, .transmit_output_b_oe_o);
  can_bus_model i_can_bus_model (.ref_clk_i, .transmit_output_a_o, .transmit_output_a_oe_o,
    .transmit_output_b_o, .transmit_output_b_oe_o, .other_dom_i(other_dom), .slow_i(slow),
    .can_rx_o(can_rx_i));

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] val);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= val;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand one cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] val);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 val = reg_rdata_o;
  endtask

  // bounded wait for sample pulses
  task automatic wait_valid(input int n);
    int k = 0;
    while (n > 0) begin
      @(posedge ref_clk_i);
      if (rx_bit_valid_o === 1'b1) n--;
      k++;
      if (k > 20000) begin
        mismatches++;
        close_out();
      end
    end
  endtask

  function automatic logic [7:0] frame_bits(input int b);
    return 8'(REMOTE_FRAME_BITS + INTERFRAME_BITS +
      BITS_PER_DATA_BYTE * (b > MAX_DATA_BYTES ? MAX_DATA_BYTES : b));
  endfunction

  // expected {a, a_oe, b, b_oe} for a stream bit
  function automatic logic [3:0] pins(input logic [7:0] c, input logic s);
    logic la, lb;
    la = s ^ c[OUT0_POL_BIT];
    lb = s ^ c[OUT1_POL_BIT];
    return {la, la ? c[OUT0_PULLUP_BIT] : c[OUT0_PULLDOWN_BIT],
      lb, lb ? c[OUT1_PULLUP_BIT] : c[OUT1_PULLDOWN_BIT]};
  endfunction

  // bit source: logs accepted bits
  always @(posedge ref_clk_i) begin
    if (tx_bit_valid_i && tx_bit_ready_o) begin
      q.push_back(tx_bit_i);
      tx_bit_i <= 1'($urandom);
    end
    tx_bit_valid_i <= feed;
  end

  // monitor takes every sample; aligns on first dominant
  always @(posedge ref_clk_i) begin
    if (chk && rx_bit_valid_o === 1'b1) begin
      if (go) begin
        check(8'(rx_bit_o), 8'(q[0]));
        check(8'({transmit_output_a_o, transmit_output_a_oe_o, transmit_output_b_o,
          transmit_output_b_oe_o}), 8'(pins(8'hAA, q[0])));
        void'(q.pop_front());
      end else if (rx_bit_o === 1'b0) begin
        go = 1'b1;
        void'(q.pop_front());
      end
    end
  end

  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    tx_bit_i = 1'b0;
    tx_bit_valid_i = 1'b0;
    {feed, chk, go, other_dom, slow} = 5'h00;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(48));
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    // reset values, then random write and read back
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      if (a != 4) check(d, a == 5 ? frame_bits(0) : 8'h00);
    end
    for (int a = 0; a < 4; a++) begin
      v = 8'($urandom);
      wr(3'(a), v);
      rd(3'(a), d);
      check(d, v);
    end
    // frame length per byte count; ignored writes
    for (int b = 0; b < 16; b++) begin
      wr(ADDR_CONTROL, {4'(b), 4'h0});
      wr(3'(4 + b % 4), 8'hFF);
      rd(ADDR_FRAME_BITS, d);
      check(d, frame_bits(b));
      rd(3'(6 + b % 2), d);
      check(d, 8'h00);
    end
    wr(ADDR_PRESCALE_JUMP, 8'h01);
    wr(ADDR_SEGMENTS, 8'h34);
    wr(ADDR_TX_DRIVER, 8'hAA);
    wr(ADDR_CONTROL, 8'h00);
    // sending off: buffer fills
    feed <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    check(8'(q.size()), 8'h02);
    check(8'(tx_bit_ready_o), 8'h00);
    chk <= 1'b1;
    wr(ADDR_CONTROL, 8'h01);
    wait_valid(6);
    rd(ADDR_STATUS, d);
    check(8'(d[STAT_TX_BUSY_BIT]), 8'h01);
    wait_valid(40);
    feed <= 1'b0;
    chk <= 1'b0;
    wait_valid(8);
    rd(ADDR_STATUS, d);
    check(d, 8'h06);
    check(8'(go), 8'h01);
    // triple sampling, all modes, another node
    wr(ADDR_SEGMENTS, 8'hB4);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_TX_DRIVER, {6'($urandom), 2'(m)});
      slow <= 1'($urandom);
      wait_valid(3);
      if (m == 0) begin
        check(8'({transmit_output_a_oe_o, transmit_output_b_oe_o}), 8'h00);
        other_dom <= 1'b1;
        wait_valid(3);
        check(8'(rx_bit_o), 8'h00);
        other_dom <= 1'b0;
      end
    end
    // second reset in mid-run
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_TX_DRIVER, d);
    check(d, TX_DRIVER_RST);
    close_out();
  end
endmodule
